/* hdl/sfl_defs.svh */
// Purpose: opcodes, field positions and reset values of the block lock logic
// Assumes: 24-bit addressing, 4 kB regions, 1024 regions
// Notes: definitions only
`ifndef SFL_DEFS_SVH
`define SFL_DEFS_SVH

// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define SFL_OP_WREN 8'h06
`define SFL_OP_VSR_WREN 8'h50
`define SFL_OP_LOCK 8'h36
`define SFL_OP_UNLOCK 8'h39
`define SFL_OP_RDLOCK_A 8'h3C
`define SFL_OP_RDLOCK_B 8'h3D
`define SFL_OP_GLOCK 8'h7E

// ------------------------------------------------------------
// address and region fields
// ------------------------------------------------------------
`define SFL_ADDR_W 24
`define SFL_REGIONS 1024
`define SFL_IDX_W 10
`define SFL_REGION_LSB 12
`define SFL_REGION_MSB 21

// ------------------------------------------------------------
// frame bit positions
// ------------------------------------------------------------
`define SFL_SH_W 12
`define SFL_BYTE_START 3'h0
`define SFL_LAST_BIT 3'h7
`define SFL_OP_BYTE 3'h0
`define SFL_IDX_BYTE 3'h2
`define SFL_IDX_BIT 3'h3
`define SFL_CMD_BYTES 3'h4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SFL_LOCK_RESET 1'b1
`define SFL_WEL_RESET 1'b0

`endif

/* hdl/sfl_pkg.sv */
// Purpose: types shared by the block lock logic
// Assumes: nothing
// Notes: constants live in sfl_defs.svh
package sfl_pkg;

    // commit sequencer states
    typedef enum logic [2:0]
    {
        SFL_ST_IDLE  = 3'b001,
        SFL_ST_LATCH = 3'b010,
        SFL_ST_APPLY = 3'b100
    } sfl_state_t;

    // action decided at the end of a frame
    typedef enum logic [5:0]
    {
        SFL_ACT_NONE   = 6'b000001,
        SFL_ACT_WREN   = 6'b000010,
        SFL_ACT_VSR    = 6'b000100,
        SFL_ACT_SET1   = 6'b001000,
        SFL_ACT_CLR1   = 6'b010000,
        SFL_ACT_SETALL = 6'b100000
    } sfl_act_t;

endpackage

/* hdl/sfl_lock_if.sv */
// Purpose: carrier between the command logic and the lock store
// Assumes: all signals on sys_clk except qry_idx and qry_bit, which follow idx_reg on spi_sclk
// Notes: lookups are combinational
`timescale 1ns/1ps
`default_nettype none
`include "sfl_defs.svh"

interface sfl_lock_if;
    logic set_one;
    logic clr_one;
    logic set_all;
    logic [`SFL_IDX_W-1:0] cmd_idx;
    logic [`SFL_IDX_W-1:0] qry_idx;
    logic qry_bit;
    logic [`SFL_IDX_W-1:0] chk_idx;
    logic chk_bit;

    modport ctrl
    (
        output set_one, clr_one, set_all, cmd_idx, qry_idx, chk_idx,
        input qry_bit, chk_bit
    );

    modport store
    (
        input set_one, clr_one, set_all, cmd_idx, qry_idx, chk_idx,
        output qry_bit, chk_bit
    );
endinterface

`default_nettype wire

/* hdl/sfl_sync.sv */
// Purpose: two-flop level synchroniser
// Assumes: d is a level that stays put for at least two clk edges
// Notes: first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none

module sfl_sync
#(
    parameter logic RST_VAL = 1'b0
)
(
    input wire logic clk,   // destination clock
    input wire logic rst_n, // async reset, active low
    input wire logic d,     // level from another domain
    output logic q          // synchronised level
);
    logic meta_reg;
    logic sync_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end
        else
        begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule

`default_nettype wire

/* hdl/sfl_lock_array.sv */
// Purpose: volatile store of one lock bit per 4 kB region
// Assumes: at most one command strobe per cycle
// Notes: set_all wins over single-region commands
`timescale 1ns/1ps
`default_nettype none
`include "sfl_defs.svh"

module sfl_lock_array
(
    input wire logic sys_clk, // system clock
    input wire logic rst_n,   // async reset, active low
    sfl_lock_if.store lk      // commands and lookups
);
    logic [`SFL_REGIONS-1:0] lock_reg;

    // ------------------------------------------------------------
    // lock bits
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_reg <= {`SFL_REGIONS{`SFL_LOCK_RESET}};
        end
        else if (lk.set_all)
        begin
            lock_reg <= {`SFL_REGIONS{1'b1}};
        end
        else if (lk.set_one)
        begin
            lock_reg[lk.cmd_idx] <= 1'b1;
        end
        else if (lk.clr_one)
        begin
            lock_reg[lk.cmd_idx] <= 1'b0;
        end
    end

    assign lk.qry_bit = lock_reg[lk.qry_idx];
    assign lk.chk_bit = lock_reg[lk.chk_idx];
endmodule

`default_nettype wire

/* hdl/sfl_block_lock.sv */
// Purpose: serial flash per-region lock command logic
// Assumes: SPI mode 0, spi_sclk idles while spi_cs_n is high
// Notes: frame results are read in the sys_clk domain after cs rises
`timescale 1ns/1ps
`default_nettype none
`include "sfl_defs.svh"

module sfl_block_lock
(
    input wire logic sys_clk,                  // system clock, 100 MHz
    input wire logic rst_n,                    // async reset, active low
    input wire logic spi_sclk,                 // serial clock from host
    input wire logic spi_cs_n,                 // chip select, active low
    input wire logic spi_si,                   // serial data in
    output logic spi_so,                       // serial data out
    output logic spi_so_oe,                    // serial out enable
    input wire logic per_block_protect_select, // use region locks
    input wire logic range_protect_hit,        // range scheme protects
    input wire logic write_latch_clear,        // clear latch pulse
    input wire logic vsr_write_done,           // volatile write used
    input wire logic pe_req,                   // program/erase check
    input wire logic [`SFL_ADDR_W-1:0] pe_addr, // target address
    output logic write_latch_flag,             // write latch state
    output logic vol_status_write_enable,      // volatile write armed
    output logic pe_grant,                     // check passed pulse
    output logic pe_refuse,                    // check refused pulse
    output logic cmd_abort                     // frame aborted pulse
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    sfl_lock_if lk();

    logic frame_clr;
    logic in_frame_reg;
    logic idx_vld_reg;
    logic [2:0] bit_pos_reg;
    logic [2:0] bit_pos_next;
    logic [2:0] byte_cnt_reg;
    logic [2:0] byte_cnt_next;
    logic [2:0] cur_pos;
    logic [2:0] cur_byte;
    logic [`SFL_SH_W-1:0] sh_reg;
    logic [`SFL_SH_W-1:0] sh_next;
    logic [7:0] op_reg;
    logic [`SFL_IDX_W-1:0] idx_reg;
    logic frame_tog_reg;
    logic rd_lock_op;
    logic so_reg;
    logic so_oe_reg;
    logic lk_bit_s;

    logic cs_s;
    logic cs_d_reg;
    logic cs_rise;
    logic tog_s;
    logic vld_s;
    logic seen_tog_reg;
    logic look_bit_reg;
    sfl_pkg::sfl_state_t state_reg;
    sfl_pkg::sfl_state_t state_next;
    logic [7:0] cap_op_reg;
    logic [`SFL_IDX_W-1:0] cap_idx_reg;
    logic [2:0] cap_pos_reg;
    logic [2:0] cap_bytes_reg;
    sfl_pkg::sfl_act_t act;
    logic aligned;
    logic has_op;
    logic has_addr;
    logic lock_family;
    logic wel_reg;
    logic vsr_reg;
    logic pe_block;
    logic pe_grant_reg;
    logic pe_refuse_reg;
    logic abort_reg;

    // ------------------------------------------------------------
    // link side: frame tracking on spi_sclk
    // ------------------------------------------------------------
    // frame-scoped flops drop as soon as cs goes high
    assign frame_clr = spi_cs_n | ~rst_n;

    always_ff @(posedge spi_sclk or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            in_frame_reg <= 1'b0;
            idx_vld_reg <= 1'b0;
        end
        else
        begin
            in_frame_reg <= 1'b1;
            if (cur_byte == `SFL_IDX_BYTE && cur_pos == `SFL_IDX_BIT)
            begin
                idx_vld_reg <= 1'b1;
            end
        end
    end

    // first edge of a frame restarts the counts
    always_comb
    begin
        cur_pos = in_frame_reg ? bit_pos_reg : `SFL_BYTE_START;
        cur_byte = in_frame_reg ? byte_cnt_reg : 3'h0;
        bit_pos_next = cur_pos + 3'h1;
        byte_cnt_next = cur_byte;
        if (cur_pos == `SFL_LAST_BIT && cur_byte != `SFL_CMD_BYTES)
        begin
            byte_cnt_next = cur_byte + 3'h1;
        end
        if (in_frame_reg)
        begin
            sh_next = {sh_reg[`SFL_SH_W-2:0], spi_si};
        end
        else
        begin
            sh_next = {{(`SFL_SH_W-1){1'b0}}, spi_si};
        end
    end

    always_ff @(posedge spi_sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_pos_reg <= 3'h0;
            byte_cnt_reg <= 3'h0;
            sh_reg <= '0;
        end
        else
        begin
            bit_pos_reg <= bit_pos_next;
            byte_cnt_reg <= byte_cnt_next;
            sh_reg <= sh_next;
        end
    end

    // opcode and region index are held after the frame for sys_clk
    always_ff @(posedge spi_sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_reg <= 8'h00;
            idx_reg <= '0;
            frame_tog_reg <= 1'b0;
        end
        else
        begin
            if (!in_frame_reg)
            begin
                frame_tog_reg <= ~frame_tog_reg;
            end
            if (cur_byte == `SFL_OP_BYTE && cur_pos == `SFL_LAST_BIT)
            begin
                op_reg <= {sh_reg[6:0], spi_si};
            end
            if (cur_byte == `SFL_IDX_BYTE && cur_pos == `SFL_IDX_BIT)
            begin
                idx_reg <= {sh_reg[8:0], spi_si};
            end
        end
    end

    // ------------------------------------------------------------
    // link side: read-lock answer on falling edges
    // ------------------------------------------------------------
    assign rd_lock_op = (op_reg == `SFL_OP_RDLOCK_A) ||
                        (op_reg == `SFL_OP_RDLOCK_B);

    always_ff @(negedge spi_sclk or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            so_oe_reg <= 1'b0;
            so_reg <= 1'b0;
        end
        else
        begin
            // drives only once opcode and full address are in
            so_oe_reg <= rd_lock_op &&
                         byte_cnt_reg == `SFL_CMD_BYTES;
            // undefined upper bits read as zero
            so_reg <= (rd_lock_op && byte_cnt_reg == `SFL_CMD_BYTES &&
                       bit_pos_reg == `SFL_LAST_BIT) ? lk_bit_s : 1'b0;
        end
    end

    assign spi_so = so_reg;
    assign spi_so_oe = so_oe_reg;

    sfl_sync #(.RST_VAL(1'b0)) u_sync_lkbit
    (
        .clk(spi_sclk),
        .rst_n(rst_n),
        .d(look_bit_reg),
        .q(lk_bit_s)
    );

    // ------------------------------------------------------------
    // crossings into sys_clk
    // ------------------------------------------------------------
    sfl_sync #(.RST_VAL(1'b1)) u_sync_cs
    (
        .clk(sys_clk),
        .rst_n(rst_n),
        .d(spi_cs_n),
        .q(cs_s)
    );

    sfl_sync #(.RST_VAL(1'b0)) u_sync_tog
    (
        .clk(sys_clk),
        .rst_n(rst_n),
        .d(frame_tog_reg),
        .q(tog_s)
    );

    sfl_sync #(.RST_VAL(1'b0)) u_sync_vld
    (
        .clk(sys_clk),
        .rst_n(rst_n),
        .d(idx_vld_reg),
        .q(vld_s)
    );

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_d_reg <= 1'b1;
        end
        else
        begin
            cs_d_reg <= cs_s;
        end
    end

    assign cs_rise = cs_s & ~cs_d_reg;

    // ------------------------------------------------------------
    // lock lookup for read-lock
    // ------------------------------------------------------------
    // idx_reg is stable while vld_s is high
    assign lk.qry_idx = idx_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            look_bit_reg <= `SFL_LOCK_RESET;
        end
        else if (vld_s)
        begin
            look_bit_reg <= lk.qry_bit;
        end
    end

    // ------------------------------------------------------------
    // commit sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            sfl_pkg::SFL_ST_IDLE:
            begin
                // a frame with no clock edges leaves tog_s unchanged
                if (cs_rise && tog_s != seen_tog_reg)
                begin
                    state_next = sfl_pkg::SFL_ST_LATCH;
                end
            end
            sfl_pkg::SFL_ST_LATCH:
            begin
                state_next = sfl_pkg::SFL_ST_APPLY;
            end
            sfl_pkg::SFL_ST_APPLY:
            begin
                state_next = sfl_pkg::SFL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= sfl_pkg::SFL_ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seen_tog_reg <= 1'b0;
            cap_op_reg <= 8'h00;
            cap_idx_reg <= '0;
            cap_pos_reg <= 3'h0;
            cap_bytes_reg <= 3'h0;
        end
        else if (state_reg == sfl_pkg::SFL_ST_LATCH)
        begin
            seen_tog_reg <= tog_s;
            cap_op_reg <= op_reg;
            cap_idx_reg <= idx_reg;
            cap_pos_reg <= bit_pos_reg;
            cap_bytes_reg <= byte_cnt_reg;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    assign aligned = (cap_pos_reg == `SFL_BYTE_START);
    assign has_op = (cap_bytes_reg != 3'h0);
    assign has_addr = (cap_bytes_reg == `SFL_CMD_BYTES);
    assign lock_family = (cap_op_reg == `SFL_OP_LOCK) ||
                         (cap_op_reg == `SFL_OP_UNLOCK) ||
                         (cap_op_reg == `SFL_OP_GLOCK);

    always_comb
    begin
        act = sfl_pkg::SFL_ACT_NONE;
        if (state_reg == sfl_pkg::SFL_ST_APPLY && aligned && has_op)
        begin
            case (cap_op_reg)
                `SFL_OP_WREN:
                begin
                    act = sfl_pkg::SFL_ACT_WREN;
                end
                `SFL_OP_VSR_WREN:
                begin
                    act = sfl_pkg::SFL_ACT_VSR;
                end
                `SFL_OP_LOCK:
                begin
                    if (has_addr && wel_reg)
                    begin
                        act = sfl_pkg::SFL_ACT_SET1;
                    end
                end
                `SFL_OP_UNLOCK:
                begin
                    if (has_addr && wel_reg)
                    begin
                        act = sfl_pkg::SFL_ACT_CLR1;
                    end
                end
                `SFL_OP_GLOCK:
                begin
                    if (wel_reg)
                    begin
                        act = sfl_pkg::SFL_ACT_SETALL;
                    end
                end
                default:
                begin
                    act = sfl_pkg::SFL_ACT_NONE;
                end
            endcase
        end
    end

    // store strobes, one cycle each
    assign lk.set_one = (act == sfl_pkg::SFL_ACT_SET1);
    assign lk.clr_one = (act == sfl_pkg::SFL_ACT_CLR1);
    assign lk.set_all = (act == sfl_pkg::SFL_ACT_SETALL);
    assign lk.cmd_idx = cap_idx_reg;

    // ------------------------------------------------------------
    // write latch and volatile write enable
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wel_reg <= `SFL_WEL_RESET;
        end
        else if (act == sfl_pkg::SFL_ACT_WREN)
        begin
            wel_reg <= 1'b1;
        end
        else if (lk.set_one || lk.clr_one || lk.set_all ||
                 write_latch_clear)
        begin
            wel_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vsr_reg <= 1'b0;
        end
        else if (act == sfl_pkg::SFL_ACT_VSR)
        begin
            vsr_reg <= 1'b1;
        end
        else if (vsr_write_done)
        begin
            vsr_reg <= 1'b0;
        end
    end

    // abort: lock-family frame misaligned or truncated
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            abort_reg <= 1'b0;
        end
        else
        begin
            // opcode from an older frame must not count
            abort_reg <= (state_reg == sfl_pkg::SFL_ST_APPLY) &&
                         lock_family && has_op && !(aligned &&
                         (has_addr || cap_op_reg == `SFL_OP_GLOCK));
        end
    end

    assign write_latch_flag = wel_reg;
    assign vol_status_write_enable = vsr_reg;
    assign cmd_abort = abort_reg;

    // ------------------------------------------------------------
    // program / erase protection check
    // ------------------------------------------------------------
    assign lk.chk_idx = pe_addr[`SFL_REGION_MSB:`SFL_REGION_LSB];
    assign pe_block = per_block_protect_select ?
                      lk.chk_bit : range_protect_hit;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pe_grant_reg <= 1'b0;
            pe_refuse_reg <= 1'b0;
        end
        else
        begin
            pe_refuse_reg <= pe_req & pe_block;
            pe_grant_reg <= pe_req & ~pe_block;
        end
    end

    assign pe_grant = pe_grant_reg;
    assign pe_refuse = pe_refuse_reg;

    // ------------------------------------------------------------
    // lock store
    // ------------------------------------------------------------
    sfl_lock_array u_array
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .lk(lk.store)
    );
endmodule

`default_nettype wire

/* sim/sfl_block_lock_props.sv */
// Purpose: port checks for the block lock logic
// Assumes: sees only the top module ports
// Notes: bound from the bench top
`timescale 1ns/1ps
`default_nettype none
`include "sfl_defs.svh"

module sfl_block_lock_props
(
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset
    input wire logic spi_sclk, // link clock
    input wire logic spi_cs_n, // select
    input wire logic spi_si, // serial in
    input wire logic spi_so, // serial out
    input wire logic spi_so_oe, // out enable
    input wire logic per_block_protect_select, // mode
    input wire logic range_protect_hit, // range result
    input wire logic write_latch_clear, // latch clear
    input wire logic vsr_write_done, // vsr clear
    input wire logic pe_req, // check request
    input wire logic [`SFL_ADDR_W-1:0] pe_addr, // check address
    input wire logic write_latch_flag, // latch
    input wire logic vol_status_write_enable, // vsr flag
    input wire logic pe_grant, // grant
    input wire logic pe_refuse, // refuse
    input wire logic cmd_abort // abort
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_pe_one_answer: assert property (
        pe_req |=> pe_grant ^ pe_refuse)
        else $error("check answer missing");
    a_pe_no_answer: assert property (
        !pe_req |=> !(pe_grant || pe_refuse))
        else $error("check answer without request");
    a_range_mode: assert property (
        pe_req && !per_block_protect_select |=>
        pe_refuse == $past(range_protect_hit))
        else $error("range scheme not followed");
    a_oe_idle: assert property (
        spi_cs_n |-> !spi_so_oe)
        else $error("out enable while deselected");
    a_so_quiet: assert property (
        !spi_so_oe |-> !spi_so)
        else $error("serial out not quiet");
    a_latch_set: assert property (
        $rose(write_latch_flag) |-> spi_cs_n && $past(spi_cs_n, 4))
        else $error("latch set outside frame end");
    a_abort_frame: assert property (
        cmd_abort |-> spi_cs_n ##1 !cmd_abort)
        else $error("abort not a frame end pulse");
    a_vsr_set: assert property (
        $rose(vol_status_write_enable) |-> $past(spi_cs_n, 4))
        else $error("vsr flag set outside frame end");
    a_latch_hold: assert property (
        !spi_cs_n && !write_latch_clear |=> $stable(write_latch_flag))
        else $error("latch moved inside a frame");

    cover property (pe_req && per_block_protect_select ##1 pe_refuse);
    cover property ($fell(write_latch_flag));
    cover property (cmd_abort);
    cover property (spi_so_oe && spi_so);
endmodule

`default_nettype wire

/* sim/sfl_spi_host.sv */
// Purpose: SPI host model driving the link in mode 0
// Assumes: 48 ns link clock, stopped between frames
// Notes: samples serial out on rising edges
`timescale 1ns/1ps
`default_nettype none

module sfl_spi_host
(
    output logic spi_sclk, // link clock
    output logic spi_cs_n, // select
    output logic spi_si, // serial in
    input wire logic spi_so // serial out
);
    initial
    begin
        spi_sclk = 0;
        spi_cs_n = 1;
        spi_si = 0;
    end

    task automatic xfer(input logic [47:0] d, input int n,
        output logic [15:0] rd);
        rd = '0;
        spi_cs_n = 0;
        #20;
        for (int i = 0; i < n; i++)
        begin
            spi_si = d[47 - i];
            #24;
            spi_sclk = 1;
            rd = {rd[14:0], spi_so};
            #24;
            spi_sclk = 0;
        end
        #20;
        spi_cs_n = 1;
        spi_si = ~spi_si;
        #200;
    endtask
endmodule

`default_nettype wire

/* sim/test_sfl_block_lock.sv */
// Purpose: self-checking bench for the block lock logic
// Assumes: host model drives the link
// Notes: checks run between frames
`timescale 1ns/1ps
`default_nettype none
`include "sfl_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
    err_count++; $display("unexpected %s exp %h got %h", n, e, g); end end

module test_sfl_block_lock;
    logic sys_clk = 0, rst_n = 0, spi_sclk, spi_cs_n, spi_si;
    logic spi_so, spi_so_oe, write_latch_flag, vol_status_write_enable;
    logic pe_grant, pe_refuse, cmd_abort, pe_req = 0;
    logic per_block_protect_select = 1, range_protect_hit = 0;
    logic write_latch_clear = 0, vsr_write_done = 0;
    logic [`SFL_ADDR_W-1:0] pe_addr = '0;
    logic [15:0] rd;
    int err_count = 0, checks = 0, aborts = 0;

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (cmd_abort === 1'b1) aborts++;

    sfl_block_lock sfl_block_lock_inst (.*);
    sfl_spi_host sfl_spi_host_inst (.*);

    task automatic print_verdict;
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic do_reset;
        @(negedge sys_clk);
        rst_n = 0;
        repeat (8) @(negedge sys_clk);
        rst_n = 1;
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic frame(input logic [7:0] op, input logic [23:0] a,
        input int n);
        @(negedge sys_clk);
        sfl_spi_host_inst.xfer({op, a, 16'h0000}, n, rd);
    endtask

    task automatic rdl(input logic [7:0] op, input logic [23:0] a,
        input logic e);
        frame(op, a, 48);
        `CHK("lock byte", {2{7'h00, e}}, rd)
    endtask

    task automatic wren;
        frame(`SFL_OP_WREN, 24'h000000, 8);
        `CHK("latch set", 1'b1, write_latch_flag)
    endtask

    task automatic pe(input logic [23:0] a, input logic e);
        @(negedge sys_clk);
        pe_req = 1;
        pe_addr = a;
        @(negedge sys_clk);
        pe_req = 0;
        `CHK("refuse", e, pe_refuse)
        `CHK("grant", ~e, pe_grant)
    endtask

    initial
    begin
        #500000;
        err_count++;
        print_verdict();
    end

    initial
    begin
        do_reset();
        pe(24'h000000, 1);
        rdl(`SFL_OP_RDLOCK_A, 24'h3FF000, 1);
        frame(`SFL_OP_UNLOCK, 24'h001234, 32);
        rdl(`SFL_OP_RDLOCK_B, 24'h001000, 1);
        wren();
        frame(`SFL_OP_UNLOCK, 24'h001234, 32);
        `CHK("latch", 1'b0, write_latch_flag)
        rdl(`SFL_OP_RDLOCK_B, 24'hC01000, 0);
        rdl(`SFL_OP_RDLOCK_A, 24'h000FFF, 1);
        pe(24'h001FFF, 0);
        per_block_protect_select = 0;
        range_protect_hit = 1;
        pe(24'h001000, 1);
        range_protect_hit = 0;
        pe(24'h000000, 0);
        per_block_protect_select = 1;
        wren();
        frame(`SFL_OP_LOCK, 24'h001000, 24);
        frame(`SFL_OP_LOCK, 24'h001000, 33);
        `CHK("aborts", 2, aborts)
        rdl(`SFL_OP_RDLOCK_A, 24'h001000, 0);
        frame(`SFL_OP_LOCK, 24'h001ABC, 32);
        rdl(`SFL_OP_RDLOCK_A, 24'h001000, 1);
        `CHK("latch", 1'b0, write_latch_flag)
        wren();
        frame(`SFL_OP_UNLOCK, 24'h005000, 32);
        frame(`SFL_OP_GLOCK, 24'h000000, 8);
        rdl(`SFL_OP_RDLOCK_A, 24'h005000, 0);
        wren();
        frame(`SFL_OP_GLOCK, 24'h000000, 12);
        frame(`SFL_OP_RDLOCK_A, 24'h000000, 37);
        `CHK("aborts", 3, aborts)
        frame(`SFL_OP_GLOCK, 24'h000000, 8);
        frame(`SFL_OP_VSR_WREN, 24'h000000, 5);
        `CHK("vsr", 1'b0, vol_status_write_enable)
        `CHK("aborts", 3, aborts)
        rdl(`SFL_OP_RDLOCK_B, 24'h005000, 1);
        `CHK("latch", 1'b0, write_latch_flag)
        frame(`SFL_OP_VSR_WREN, 24'h000000, 8);
        `CHK("vsr", 1'b1, vol_status_write_enable)
        wren();
        @(negedge sys_clk);
        vsr_write_done = 1;
        write_latch_clear = 1;
        @(negedge sys_clk);
        vsr_write_done = 0;
        write_latch_clear = 0;
        `CHK("vsr", 1'b0, vol_status_write_enable)
        `CHK("latch", 1'b0, write_latch_flag)
        wren();
        frame(`SFL_OP_UNLOCK, 24'h002000, 32);
        rdl(`SFL_OP_RDLOCK_A, 24'h002000, 0);
        do_reset();
        rdl(`SFL_OP_RDLOCK_A, 24'h002000, 1);
        print_verdict();
    end
endmodule

bind sfl_block_lock sfl_block_lock_props sfl_block_lock_props_inst (.*);

`default_nettype wire
